// file: src/dvr_pkg.sv
// Shared constants for the divider rate feedback network and its controller.
package dvr_pkg;
    localparam int         DIGITS         = 6;
    localparam int         DW             = 4;
    localparam int         FW             = 5;
    localparam logic [2:0] FETCH_FIRST    = 3'h0;
    localparam logic [2:0] FETCH_BORROW   = 3'h5;
    localparam logic [2:0] FETCH_CFG      = 3'h6;
    localparam logic [3:0] UNIT_LAST      = 4'h9;
    localparam logic [3:0] DECADE_LAST    = 4'h9;
    localparam logic [4:0] BASE_DEC       = 5'h0A;
    localparam logic [4:0] M_MAX          = 5'h10;
    localparam logic [3:0] SLAVE_A2       = 4'hB;
    localparam logic [3:0] SLAVE_B2       = 4'hA;
    localparam int         HALF_EN_BIT    = 0;
    localparam int         HALF_OFS_BIT   = 1;
    localparam logic [4:0] M_RESET        = 5'h01;
    // Controller register byte offsets on Wishbone.
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_DIGIT_A    = 8'h04;
    localparam logic [7:0] REG_DIGIT_B    = 8'h08;
    localparam logic [7:0] REG_CFG        = 8'h0C;
    localparam logic [7:0] REG_STATUS     = 8'h10;
    localparam int         CTRL_START     = 0;
    localparam int         CTRL_RATE      = 1;
    localparam int         CTRL_BORROW    = 2;
    localparam logic [7:0] FETCH_GAP      = 8'h04;
endpackage

// file: src/dvr_link_if.sv
// Link between the divider feedback network and its programming controller.
`timescale 1ns/1ns
interface dvr_link_if;
    logic       load;
    logic [2:0] period;
    logic [3:0] data_a;
    logic [3:0] data_b;
    logic       borrow_si;
    logic       rate_chain_input_n;
    logic       feedback_out_fast_n;
    logic       feedback_out_mid_n;
    logic       feedback_out_slow_or_borrow_n;
    logic       prescaler_sync_output_n;

    modport dev (
        input  load, period, data_a, data_b, borrow_si, rate_chain_input_n,
        output feedback_out_fast_n, feedback_out_mid_n,
               feedback_out_slow_or_borrow_n, prescaler_sync_output_n
    );
    modport ctl (
        output load, period, data_a, data_b, borrow_si, rate_chain_input_n,
        input  feedback_out_fast_n, feedback_out_mid_n,
               feedback_out_slow_or_borrow_n, prescaler_sync_output_n
    );
endinterface

// file: src/dvr_rate_sel.sv
// One rate selector: active in n of its timer states, passes through in the last.
`timescale 1ns/1ns
module dvr_rate_sel #(
    parameter int W = 4
) (
    // Timing state and programmed digit.
    input  wire logic [W-1:0] state_i,
    input  wire logic [W-1:0] digit_i,
    input  wire logic [W-1:0] last_i,
    // Lower selector output forwarded in the idle state.
    input  wire logic         pass_i,
    output logic              active_o
);
    // The digit never reaches the last state, so that state is always idle.
    assign active_o = (state_i < digit_i) || ((state_i == last_i) && pass_i);
endmodule

// file: src/dvr_device_end.sv
// Rate selector feedback network, prescaler sync and output stage of the divider.
// Summary of operation
// - Feedback pulse stretches counter ratio by one
// - Decade counter gives ten timing periods
// - Selector with digit n active n of ten
// - First upper selector passes fraction selector when idle
// - Fraction selector passes half-channel selector once
// - Half-channel selector forwards rate input per mode
// - Unused rate input held high outside
// - First three upper selectors drive low feedback outputs
// - Feedback outputs routed by prescaler frequency order
// - Sync output low in last input period
// - Earlier prescaler sync is active-low OR outside
// - Slave mode decoded from programmed digit pattern
// - Slave acts as two lower programmable stages
// - Slave third feedback carries subtractor borrow
// - Serial borrow input sampled in fetch period zero
// - Borrow input tied to next slave or low
// - Cascaded dividers programmed in significance order
// - Rate input and slow output chained to slave
// - Slow output gives evenly spaced low pulses
// - Fast output at M times H slow rate
// - Borrow input high means borrow
// - Config bit zero enables half channel, one offsets
`timescale 1ns/1ns
module dvr_device_end
    import dvr_pkg::*;
(
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Link to controller and prescalers.
    dvr_link_if.dev   link,
    // Divider outputs.
    output logic      fast_output_n_o,
    output logic      slow_output_n_o,
    output logic      slave_mode_o
);
    logic [DW-1:0] raw_a_r [DIGITS];
    logic [DW-1:0] raw_b_r [DIGITS];
    logic [DW-1:0] digit_r [DIGITS];
    logic          borrow_r;
    logic [FW-1:0] m_r;
    logic [1:0]    half_cfg_r;

    logic          bin;
    logic          neg;
    logic [FW-1:0] base;
    logic [FW-1:0] diff;
    logic          slave;

    logic [DW-1:0] unit_cnt_r;
    logic          stretch_r;
    logic [FW-1:0] frac_cnt_r;
    logic          half_cnt_r;
    logic [DW-1:0] dec_cnt_r;
    logic [DW-1:0] ms_cnt_r;
    logic          ms_stretch_r;

    logic [DW-1:0] unit_end;
    logic          base_tick;
    logic          frac_wrap;
    logic          dec_step;
    logic          dec_wrap;
    logic [DW-1:0] ms_digit;
    logic [DW-1:0] ms_end;
    logic          half_en;
    logic          rsh_act;
    logic          rs0_act;
    logic [4:1]    rs_act;
    logic [FW-1:0] frac_last;

    // Digit subtractor: one BCD digit per fetch period, borrow ripples forward.
    always_comb begin
        bin  = (link.period == FETCH_FIRST) ? link.borrow_si : borrow_r;
        base = (link.period == FETCH_FIRST) ? m_r : BASE_DEC;
        neg  = ({1'b0, link.data_a} < ({1'b0, link.data_b} + {4'h0, bin}));
        diff = {1'b0, link.data_a} + (neg ? base : 5'h00)
               - {1'b0, link.data_b} - {4'h0, bin};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DIGITS; i++) begin
                raw_a_r[i] <= 4'h0;
                raw_b_r[i] <= 4'h0;
                digit_r[i] <= 4'h0;
            end
            borrow_r <= 1'b0;
        end else if (link.load && (link.period < FETCH_CFG)) begin
            raw_a_r[link.period] <= link.data_a;
            raw_b_r[link.period] <= link.data_b;
            digit_r[link.period] <= diff[DW-1:0];
            borrow_r             <= neg;
        end
    end

    // Configuration period: M (zero code means sixteen) and half-channel mode.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            m_r        <= M_RESET;
            half_cfg_r <= 2'h0;
        end else if (link.load && (link.period == FETCH_CFG)) begin
            m_r        <= (link.data_a == 4'h0) ? M_MAX : {1'b0, link.data_a};
            half_cfg_r <= link.data_b[1:0];
        end
    end

    assign slave = (raw_a_r[2] == SLAVE_A2) && (raw_b_r[2] == SLAVE_B2)
                   && (raw_a_r[3] == 4'h0) && (raw_a_r[4] == 4'h0)
                   && (raw_b_r[3] == 4'h0) && (raw_b_r[4] == 4'h0)
                   && (raw_b_r[5] == 4'h0);

    assign half_en   = half_cfg_r[HALF_EN_BIT];
    assign frac_last = m_r - 5'h01;

    // The most significant counter takes the top non-zero digit; a slave has none.
    always_comb begin
        ms_digit = 4'h1;
        if (!slave) begin
            for (int k = 2; k < DIGITS; k++) begin
                if (digit_r[k] != 4'h0) begin
                    ms_digit = digit_r[k];
                end
            end
        end
    end

    assign unit_end  = UNIT_LAST + {3'h0, stretch_r};
    assign base_tick = (unit_cnt_r == unit_end);
    // A smaller M loaded mid-count must not leave the counter running past its end.
    assign frac_wrap = base_tick && (frac_cnt_r >= frac_last);
    assign dec_step  = frac_wrap && (!half_en || half_cnt_r);
    assign dec_wrap  = dec_step && (dec_cnt_r == DECADE_LAST);
    assign ms_end    = ms_digit - 4'h1 + {3'h0, ms_stretch_r};

    // Half-channel selector forwards the active-low rate input.
    assign rsh_act = !link.rate_chain_input_n
                     && (!half_en || (half_cnt_r == half_cfg_r[HALF_OFS_BIT]));

    dvr_rate_sel #(.W(FW)) u_fraction_rate_selector (
        .state_i  (frac_cnt_r),
        .digit_i  ({1'b0, digit_r[0]}),
        .last_i   (frac_last),
        .pass_i   (rsh_act),
        .active_o (rs0_act)
    );

    // Upper selectors share the decade state; only the first one chains down.
    for (genvar g = 1; g <= 4; g++) begin : g_upper
        dvr_rate_sel #(.W(DW)) u_upper_rate_selector (
            .state_i  (dec_cnt_r),
            .digit_i  (slave && (g > 2) ? 4'h0 : digit_r[g]),
            .last_i   (DECADE_LAST),
            .pass_i   ((g == 1) ? rs0_act : 1'b0),
            .active_o (rs_act[g])
        );
    end

    // Unit counter, side-stepped by the first upper selector.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unit_cnt_r <= 4'h0;
            stretch_r  <= 1'b0;
        end else if (base_tick) begin
            unit_cnt_r <= 4'h0;
            stretch_r  <= rs_act[1];
        end else begin
            unit_cnt_r <= unit_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frac_cnt_r <= 5'h00;
        end else if (frac_wrap) begin
            frac_cnt_r <= 5'h00;
        end else if (base_tick) begin
            frac_cnt_r <= frac_cnt_r + 5'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            half_cnt_r <= 1'b0;
        end else if (frac_wrap && half_en) begin
            half_cnt_r <= !half_cnt_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_cnt_r <= 4'h0;
        end else if (dec_wrap) begin
            dec_cnt_r <= 4'h0;
        end else if (dec_step) begin
            dec_cnt_r <= dec_cnt_r + 4'h1;
        end
    end

    // Most significant counter, side-stepped by the top selector.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ms_cnt_r     <= 4'h0;
            ms_stretch_r <= 1'b0;
        end else if (dec_wrap) begin
            if (ms_cnt_r >= ms_end) begin
                ms_cnt_r     <= 4'h0;
                ms_stretch_r <= rs_act[4];
            end else begin
                ms_cnt_r <= ms_cnt_r + 4'h1;
            end
        end
    end

    // Registered link outputs, active low except the slave-mode borrow, which is high for a borrow.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link.feedback_out_fast_n          <= 1'b1;
            link.feedback_out_mid_n           <= 1'b1;
            link.feedback_out_slow_or_borrow_n <= 1'b1;
            link.prescaler_sync_output_n      <= 1'b1;
        end else begin
            link.feedback_out_fast_n <= !rs_act[1];
            link.feedback_out_mid_n  <= !rs_act[2];
            link.feedback_out_slow_or_borrow_n <= slave ? borrow_r : !rs_act[3];
            link.prescaler_sync_output_n <= !(base_tick ? 1'b0
                                            : (unit_cnt_r + 4'h1 == unit_end));
        end
    end

    // Fast output every basic period; slow output every M*H periods.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_output_n_o <= 1'b1;
            slow_output_n_o <= 1'b1;
            slave_mode_o    <= 1'b0;
        end else begin
            fast_output_n_o <= !base_tick;
            slow_output_n_o <= !dec_step;
            slave_mode_o    <= slave;
        end
    end
endmodule

// file: src/dvr_ctl_end.sv
// Programming controller end: Wishbone registers, fetch sequencer, sync combine.
`timescale 1ns/1ns
module dvr_ctl_end
    import dvr_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Prescaler sync chain.
    input  wire logic        next_sync_in_n_i,
    output logic             prev_sync_n_o,
    // Link to the divider.
    dvr_link_if.ctl          link
);
    logic [23:0] digit_a_r;
    logic [23:0] digit_b_r;
    logic [7:0]  cfg_r;
    logic        rate_r;
    logic        borrow_in_r;
    logic        busy_r;
    logic [7:0]  gap_r;
    logic [2:0]  fetch_r;
    logic        req;
    logic        wr;
    logic        gap_tick;

    assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // A write lands at the edge where the master samples ack high, while it still holds stb.
    assign wr       = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    assign gap_tick = busy_r && (gap_r == FETCH_GAP);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            case (wb_adr_i)
                REG_CTRL:    wb_dat_o <= {29'h0, borrow_in_r, rate_r, busy_r};
                REG_DIGIT_A: wb_dat_o <= {8'h00, digit_a_r};
                REG_DIGIT_B: wb_dat_o <= {8'h00, digit_b_r};
                REG_CFG:     wb_dat_o <= {24'h0, cfg_r};
                REG_STATUS:  wb_dat_o <= {27'h0, link.prescaler_sync_output_n,
                                          link.feedback_out_slow_or_borrow_n,
                                          link.feedback_out_mid_n,
                                          link.feedback_out_fast_n, busy_r};
                default:     wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Register writes; the whole word is taken when byte lane zero is enabled.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            digit_a_r   <= 24'h00_0000;
            digit_b_r   <= 24'h00_0000;
            cfg_r       <= 8'h00;
            rate_r      <= 1'b0;
            borrow_in_r <= 1'b0;
        end else if (wr) begin
            case (wb_adr_i)
                REG_CTRL: begin
                    rate_r      <= wb_dat_i[CTRL_RATE];
                    borrow_in_r <= wb_dat_i[CTRL_BORROW];
                end
                REG_DIGIT_A: digit_a_r <= wb_dat_i[23:0];
                REG_DIGIT_B: digit_b_r <= wb_dat_i[23:0];
                REG_CFG:     cfg_r     <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Fetch sequencer: periods 0 to 6, one load pulse per gap.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_r  <= 1'b0;
            gap_r   <= 8'h00;
            fetch_r <= FETCH_FIRST;
        end else if (!busy_r) begin
            if (wr && (wb_adr_i == REG_CTRL) && wb_dat_i[CTRL_START]) begin
                busy_r  <= 1'b1;
                gap_r   <= 8'h00;
                fetch_r <= FETCH_FIRST;
            end
        end else if (gap_tick) begin
            gap_r   <= 8'h00;
            fetch_r <= fetch_r + 3'h1;
            busy_r  <= (fetch_r != FETCH_CFG);
        end else begin
            gap_r <= gap_r + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link.load               <= 1'b0;
            link.period             <= FETCH_FIRST;
            link.data_a             <= 4'h0;
            link.data_b             <= 4'h0;
            link.borrow_si          <= 1'b0;
            link.rate_chain_input_n <= 1'b1;
            prev_sync_n_o           <= 1'b1;
        end else begin
            link.load   <= gap_tick && (fetch_r <= FETCH_CFG);
            // Period, data and borrow change only with a load and then hold until the next.
            if (gap_tick) begin
                link.period <= fetch_r;
                if (fetch_r == FETCH_CFG) begin
                    link.data_a <= cfg_r[3:0];
                    link.data_b <= cfg_r[7:4];
                end else begin
                    link.data_a <= digit_a_r[{fetch_r, 2'b00} +: 4];
                    link.data_b <= digit_b_r[{fetch_r, 2'b00} +: 4];
                end
                link.borrow_si <= (fetch_r == FETCH_FIRST) && borrow_in_r;
            end
            link.rate_chain_input_n <= !rate_r;
            prev_sync_n_o <= next_sync_in_n_i && link.prescaler_sync_output_n;
        end
    end
endmodule

// file: testbench/dvr_link_assertions.sv
// Timing and protocol checks on the link between divider network and controller.
`timescale 1ns/1ns
module dvr_link_assertions
    import dvr_pkg::*;
(
    // Clock and reset.
    input wire logic       clk_i,
    input wire logic       rst_i,
    // Link signals.
    input wire logic       load,
    input wire logic [2:0] period,
    input wire logic [3:0] data_a,
    input wire logic [3:0] data_b,
    input wire logic       borrow_si,
    input wire logic       rate_chain_input_n,
    input wire logic       feedback_out_fast_n,
    input wire logic       feedback_out_mid_n,
    input wire logic       feedback_out_slow_or_borrow_n,
    input wire logic       prescaler_sync_output_n
);
    wire logic sy_n = prescaler_sync_output_n;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_sync_single: assert property (!sy_n |=> sy_n[*8])
        else $error("sync low too long");
    a_sync_period: assert property (!sy_n |-> ##[10:11] !sy_n)
        else $error("basic period not 10 or 11");
    a_load_gap: assert property (load |=> !load[*4])
        else $error("loads too close");
    a_load_order: assert property (load && period < FETCH_CFG |->
        ##5 (load && period == $past(period, 5) + 3'h1)) else $error("fetch order broken");
    a_load_range: assert property (load |-> period <= FETCH_CFG)
        else $error("fetch period too high");
    a_data_hold: assert property (load |=>
        ($stable(data_a) && $stable(data_b) && $stable(period))[*4]) else $error("data moved");
    a_borrow_fetch: assert property (borrow_si |-> period == FETCH_FIRST)
        else $error("borrow outside period zero");
    a_reset_idle: assert property ($fell(rst_i) |-> !load && sy_n && rate_chain_input_n
        && feedback_out_fast_n && feedback_out_mid_n && feedback_out_slow_or_borrow_n)
        else $error("link not idle after reset");

    c_cfg_load: cover property (load && period == FETCH_CFG);
    c_fb_fast: cover property (!feedback_out_fast_n && !sy_n);
    c_borrow: cover property (borrow_si && load);
endmodule

// file: testbench/tb.sv
// Self-checking bench for the divider network and its programming controller.
`timescale 1ns/1ns
module tb
    import dvr_pkg::*;
;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, next_sync_in_n_i;
    logic        prev_sync_n_o, fast_output_n_o, slow_output_n_o, slave_mode_o, rate_on, s_bin;
    logic [3:0]  wb_sel_i;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [3:0]  s_a [8];
    logic [3:0]  s_b [8];
    int          n_errors, check_count, cyc_cnt, loads, clks, nf, nm, nfo, nso, npl, sgap;

    dvr_link_if link ();
    dvr_device_end dvr_device_end_i (.clk_i, .rst_i, .link, .fast_output_n_o, .slow_output_n_o,
        .slave_mode_o);
    dvr_ctl_end dvr_ctl_end_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .next_sync_in_n_i, .prev_sync_n_o, .link);
    dvr_link_assertions dvr_link_assertions_i (.clk_i, .rst_i, .load(link.load),
        .period(link.period), .data_a(link.data_a), .data_b(link.data_b),
        .borrow_si(link.borrow_si), .rate_chain_input_n(link.rate_chain_input_n),
        .feedback_out_fast_n(link.feedback_out_fast_n),
        .feedback_out_mid_n(link.feedback_out_mid_n),
        .feedback_out_slow_or_borrow_n(link.feedback_out_slow_or_borrow_n),
        .prescaler_sync_output_n(link.prescaler_sync_output_n));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Records what the controller hands over at each fetch period; also cuts a hang short.
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (link.load === 1'b1) begin
            s_a[link.period] <= link.data_a;
            s_b[link.period] <= link.data_b;
            loads <= loads + 1;
            if (link.period === FETCH_FIRST)
                s_bin <= link.borrow_si;
        end
        if (cyc_cnt == 6000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                            output logic [31:0] rd);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= wd;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        check("bus ack", i, 2);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_sel_i <= 4'h0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] x;
        wb_cycle(1'b1, adr, d, x);
    endtask

    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp, input string what);
        logic [31:0] x;
        wb_cycle(1'b0, adr, 32'h0, x);
        check(what, x, exp);
    endtask

    task automatic set_rate(input logic v);
        rate_on = v;
        wr(REG_CTRL, {29'h0, 1'b0, v, 1'b0});
    endtask

    // Programs both numbers and the configuration, then waits for the sequencer to finish.
    task automatic prog(input logic [23:0] a, input logic [23:0] b, input logic [7:0] cfg,
                        input logic bin);
        logic [31:0] x;
        int i;
        wr(REG_DIGIT_A, {8'h00, a});
        wr(REG_DIGIT_B, {8'h00, b});
        wr(REG_CFG, {24'h0, cfg});
        loads = 0;
        wr(REG_CTRL, {29'h0, bin, rate_on, 1'b1});
        i = 0;
        do begin
            wb_cycle(1'b0, REG_STATUS, 32'h0, x);
            i++;
        end while (x[0] !== 1'b0 && i < 40);
        check("prog done", x[0], 1'b0);
        repeat (4) @(posedge clk_i);
    endtask

    // Counts clocks, pulses and feedback over np whole basic periods.
    task automatic measure(input int np);
        int i, cnt, t0;
        {clks, nf, nm, nfo, nso, npl, sgap, cnt} = '0;
        t0 = -1;
        for (i = 0; i < 3000 && cnt <= np; i++) begin
            @(negedge clk_i);
            if (cnt > 0) begin
                clks++;
                nfo += int'(fast_output_n_o === 1'b0);
                npl += int'(prev_sync_n_o === 1'b0);
                if (slow_output_n_o === 1'b0) begin
                    nso++;
                    if (t0 >= 0 && sgap == 0)
                        sgap = clks - t0;
                    t0 = clks;
                end
            end
            if (link.prescaler_sync_output_n === 1'b0) begin
                nf += int'(cnt > 0 && link.feedback_out_fast_n === 1'b0);
                nm += int'(cnt > 0 && link.feedback_out_mid_n === 1'b0);
                cnt++;
            end
        end
        @(posedge clk_i);
    endtask

    initial begin
        logic [31:0] x;
        int k;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} = '0;
        next_sync_in_n_i = 1'b1;
        rate_on = 1'b0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_cycle(1'b0, REG_STATUS, 32'h0, x);
        check("status idle", x & 32'hF, 32'hE);
        rdc(REG_CTRL, 32'h0, "ctrl reset");
        wr(8'h14, 32'hFFFF_FFFF);
        rdc(8'h14, 32'h0, "unmapped");
        set_rate(1'b1);
        rdc(REG_CTRL, 32'h2, "ctrl rate");
        check("rate line", link.rate_chain_input_n, 1'b0);
        set_rate(1'b0);
        rdc(REG_CTRL, 32'h0, "ctrl idle");
        check("rate idle", link.rate_chain_input_n, 1'b1);
        $display("test registers done");
        next_sync_in_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check("prev sync held", prev_sync_n_o, 1'b0);
        next_sync_in_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        measure(10);
        check("period clocks", clks, 100);
        check("prev sync", npl, 10);
        check("fast pulses", nfo, 10);
        check("slow pulses", nso, 10);
        check("fb idle", nf + nm, 0);
        $display("test sync done");
        prog(24'h987654, 24'h012345, 8'h37, 1'b1);
        check("loads", loads, 7);
        for (k = 0; k < 6; k++) begin
            check("digit a", s_a[k], (32'h987654 >> (4 * k)) & 32'hF);
            check("digit b", s_b[k], (32'h012345 >> (4 * k)) & 32'hF);
        end
        check("cfg a", s_a[6], 32'h7);
        check("cfg b", s_b[6], 32'h3);
        check("borrow in", s_bin, 1'b1);
        $display("test fetch done");
        prog(24'h000530, 24'h0, 8'h01, 1'b0);
        prog(24'h000530, 24'h0, 8'h01, 1'b0);
        check("borrow clear", s_bin, 1'b0);
        measure(10);
        check("fb fast", nf, 3);
        check("fb mid", nm, 5);
        check("stretched clocks", clks, 103);
        check("fast per period", nfo, 10);
        set_rate(1'b1);
        measure(10);
        check("fb with rate", nf, 4);
        check("rate clocks", clks, 104);
        set_rate(1'b0);
        $display("test feedback done");
        prog(24'h0, 24'h0, 8'h12, 1'b0);
        prog(24'h0, 24'h0, 8'h12, 1'b0);
        measure(20);
        check("half clocks", clks, 200);
        check("slow count", nso, 5);
        check("slow spacing", sgap, 40);
        check("fast count", nfo, 20);
        set_rate(1'b1);
        measure(40);
        check("half rate fb", nf, 1);
        set_rate(1'b0);
        $display("test half channel done");
        prog(24'h000B00, 24'h000A00, 8'h01, 1'b0);
        prog(24'h000B00, 24'h000A00, 8'h01, 1'b0);
        check("slave on", slave_mode_o, 1'b1);
        check("slave borrow", link.feedback_out_slow_or_borrow_n, 1'b0);
        prog(24'h0, 24'h0, 8'h01, 1'b0);
        check("slave off", slave_mode_o, 1'b0);
        $display("test slave done");
        end_of_test();
    end
endmodule
